// file: shared/mac_pkg.sv
`default_nettype none
package mac_pkg;
  localparam logic [4:0] REG_CMD      = 5'h00;
  localparam logic [4:0] REG_RCFG     = 5'h01;
  localparam logic [4:0] REG_FIRST    = 5'h02;
  localparam logic [4:0] REG_END      = 5'h03;
  localparam logic [4:0] REG_BOUNDARY = 5'h04;
  localparam logic [4:0] REG_WPAGE    = 5'h05;
  localparam logic [4:0] REG_STAT     = 5'h06;
  localparam logic [4:0] REG_TPAGE    = 5'h07;
  localparam logic [4:0] REG_TCNT_LO  = 5'h08;
  localparam logic [4:0] REG_TCNT_HI  = 5'h09;
  localparam logic [4:0] REG_RADDR_LO = 5'h0A;
  localparam logic [4:0] REG_RADDR_HI = 5'h0B;
  localparam logic [4:0] REG_DPORT    = 5'h0C;
  localparam logic [4:0] REG_COLL     = 5'h0D;
  localparam logic [1:0] REG_STA_HI   = 2'b10;
  localparam logic [1:0] REG_MAR_HI   = 2'b11;
  localparam logic [2:0] STA_BYTES    = 3'd6;
  localparam int CMD_RX_ON   = 0;
  localparam int CMD_TX_GO   = 1;
  localparam int CMD_IO_MODE = 2;
  localparam int CMD_SEED    = 3;
  localparam int RCFG_PHYS   = 0;
  localparam int RCFG_BCAST  = 1;
  localparam int RCFG_MCAST  = 2;
  localparam int RCFG_PROM   = 3;
  localparam int ST_RX_OK    = 0;
  localparam int ST_CRC_ERR  = 1;
  localparam int ST_RING_OVERWRITE_FLAG = 2;
  localparam int ST_TX_DONE  = 3;
  localparam int ST_TX_ABORT = 4;
  localparam int ST_RX_BAD   = 5;
  localparam int RXS_OK      = 0;
  localparam int RXS_MC      = 5;
  localparam logic [6:0]  PRE_LAST    = 7'd61;
  localparam logic [6:0]  SFD_LAST    = 7'd1;
  localparam logic [6:0]  FCS_LAST    = 7'd31;
  localparam logic [6:0]  JAM_LAST    = 7'd31;
  localparam logic [7:0]  STAT_OFS    = 8'h04;
  localparam logic [1:0]  STAT_LAST   = 2'd3;
  localparam logic [4:0]  MAX_RETRY   = 5'd15;
  localparam logic [4:0]  BO_EXP_MAX  = 5'd10;
  localparam int          SLOT_SHIFT  = 9;
  localparam logic [15:0] RUNT_BYTES  = 16'h0040;
  localparam logic [15:0] DA_LAST     = 16'h0005;
  localparam logic [31:0] CRC_POLY    = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hC704DD7B;
  typedef enum logic [2:0] {R_IDLE, R_PRE, R_DATA, R_DROP, R_STAT} rx_state_e;
  typedef enum logic [2:0] {T_IDLE, T_PRE, T_SFD, T_DATA, T_FCS, T_JAM, T_BACK, T_END} tx_state_e;
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic d);
    crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ d) ? CRC_POLY : 32'h00000000);
  endfunction : crc_step
  function automatic logic [7:0] next_page(input logic [7:0] p, input logic [7:0] f,
                                           input logic [7:0] e);
    next_page = (8'(p + 8'h01) == e) ? f : 8'(p + 8'h01);
  endfunction : next_page
endpackage : mac_pkg
`default_nettype wire

// file: logic/mac_core.sv
`default_nettype none
module mac_core
  import mac_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        rx_clk,
  input  wire logic        rx_data,
  input  wire logic        rx_crs,
  input  wire logic        tx_clk,
  input  wire logic        col,
  output logic             tx_data,
  output logic             tx_en,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  input  wire logic [7:0]  mem_rdata
);
  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    rx_state_e   rs;
    logic [7:0]  rsh;
    logic [2:0]  rbit;
    logic [15:0] rcnt;
    logic        prev1;
    logic [31:0] rcrc;
    logic [47:0] da;
    logic        mc;
    logic [15:0] rdma;
    logic        rwp;
    logic [15:0] rwa;
    logic [7:0]  rwb;
    logic [1:0]  sidx;
    logic [7:0]  npg;
    tx_state_e   ts;
    logic [7:0]  tsh;
    logic [2:0]  tbit;
    logic [15:0] tleft;
    logic [15:0] fleft;
    logic [15:0] taddr;
    logic [7:0]  tnext;
    logic        tnv;
    logic        tfp;
    logic [31:0] tcrc;
    logic [6:0]  tcnt;
    logic [18:0] bo;
    logic [4:0]  coll;
    logic [9:0]  lfsr;
    logic        txd;
    logic        txen;
    logic        rx_on;
    logic        tx_go;
    logic        io_mode;
    logic [3:0]  rcfg;
    logic [7:0]  ring_first_page;
    logic [7:0]  ring_end_page;
    logic [7:0]  boundary_page;
    logic [7:0]  write_page;
    logic [5:0]  stat;
    logic [7:0]  tpage;
    logic [15:0] tcount;
    logic [15:0] raddr;
    logic [7:0]  rdat;
    logic        rwq;
    logic [7:0]  rwd;
    logic        rpf;
    logic [47:0] sta;
    logic [63:0] mar;
    logic [7:0]  rdata;
    logic [15:0] maddr;
    logic [7:0]  mwd;
    logic        mwe;
    logic        mre;
    logic        own;
    logic        mre_d;
    logic        own_d;
  } state_s;

  state_s st;
  state_s next_st;
  logic   rxe;
  logic   rxd;
  logic   crs;
  logic   txe;
  logic   colv;

  assign rxe  = st.s2[0] & ~st.s3[0];
  assign rxd  = st.s2[1];
  assign crs  = st.s2[2];
  assign txe  = st.s2[3] & ~st.s3[3];
  assign colv = st.s2[4];

  always_comb begin
    logic [5:0]  set;
    logic [5:0]  clr;
    logic [7:0]  rb;
    logic [47:0] daf;
    logic [5:0]  hash;
    logic        acc;
    logic [7:0]  pg;
    logic [4:0]  ce;
    logic [9:0]  mask;
    state_s n;
    set  = '0;
    clr  = '0;
    rb   = '0;
    daf  = '0;
    hash = '0;
    acc  = 1'b0;
    pg   = '0;
    ce   = '0;
    mask = '0;
    n = st;
    n.s1 = {col, tx_clk, rx_crs, rx_data, rx_clk};
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.lfsr = {st.lfsr[8:0], ~(st.lfsr[9] ^ st.lfsr[6])};
    n.mre_d = st.mre;
    n.own_d = st.own;
    n.mwe = 1'b0;
    n.mre = 1'b0;
    n.rdata = 8'h00;
    if (st.mre_d) begin
      if (st.own_d) begin
        n.rdat = mem_rdata;
      end else begin
        n.tnext = mem_rdata;
        n.tnv = 1'b1;
        n.tfp = 1'b0;
      end
    end
    if (st.rwp) begin
      n.mwe = 1'b1;
      n.maddr = st.rwa;
      n.mwd = st.rwb;
      n.rwp = 1'b0;
    end else if (st.ts inside {T_PRE, T_SFD, T_DATA} && !st.tnv && !st.tfp
                 && st.fleft != 16'h0000) begin
      n.mre = 1'b1;
      n.own = 1'b0;
      n.maddr = st.taddr;
      n.taddr = st.taddr + 16'h0001;
      n.fleft = st.fleft - 16'h0001;
      n.tfp = 1'b1;
    end else if (st.rwq) begin
      n.mwe = 1'b1;
      n.maddr = st.raddr;
      n.mwd = st.rwd;
      n.raddr = st.raddr + 16'h0001;
      n.rwq = 1'b0;
    end else if (st.rpf) begin
      n.mre = 1'b1;
      n.own = 1'b1;
      n.maddr = st.raddr;
      n.rpf = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        REG_CMD: begin
          n.rx_on = reg_wdata[CMD_RX_ON];
          n.tx_go = st.tx_go | reg_wdata[CMD_TX_GO];
          n.io_mode = reg_wdata[CMD_IO_MODE];
          if (reg_wdata[CMD_SEED] && reg_wdata[CMD_IO_MODE]) begin
            n.raddr = {st.boundary_page, 8'h00};
            n.rpf = 1'b1;
          end
        end
        REG_RCFG:     n.rcfg = reg_wdata[3:0];
        REG_FIRST:    n.ring_first_page = reg_wdata;
        REG_END:      n.ring_end_page = reg_wdata;
        REG_BOUNDARY: n.boundary_page = reg_wdata;
        REG_WPAGE:    n.write_page = reg_wdata;
        REG_STAT:     clr = reg_wdata[5:0];
        REG_TPAGE:    n.tpage = reg_wdata;
        REG_TCNT_LO:  n.tcount[7:0] = reg_wdata;
        REG_TCNT_HI:  n.tcount[15:8] = reg_wdata;
        REG_RADDR_LO: n.raddr[7:0] = reg_wdata;
        REG_RADDR_HI: begin
          n.raddr[15:8] = reg_wdata;
          n.rpf = st.io_mode;
        end
        // data port only in I/O mode
        REG_DPORT: begin
          n.rwq = st.io_mode;
          n.rwd = reg_wdata;
        end
        default: begin
          if (reg_addr[4:3] == REG_MAR_HI) begin
            n.mar[{reg_addr[2:0], 3'b000} +: 8] = reg_wdata;
          end else if (reg_addr[4:3] == REG_STA_HI && reg_addr[2:0] < STA_BYTES) begin
            n.sta[{reg_addr[2:0], 3'b000} +: 8] = reg_wdata;
          end
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CMD:      n.rdata = {5'h00, st.io_mode, st.tx_go, st.rx_on};
        REG_RCFG:     n.rdata = {4'h0, st.rcfg};
        REG_FIRST:    n.rdata = st.ring_first_page;
        REG_END:      n.rdata = st.ring_end_page;
        REG_BOUNDARY: n.rdata = st.boundary_page;
        REG_WPAGE:    n.rdata = st.write_page;
        REG_STAT:     n.rdata = {2'b00, st.stat};
        REG_TPAGE:    n.rdata = st.tpage;
        REG_TCNT_LO:  n.rdata = st.tcount[7:0];
        REG_TCNT_HI:  n.rdata = st.tcount[15:8];
        REG_RADDR_LO: n.rdata = st.raddr[7:0];
        REG_RADDR_HI: n.rdata = st.raddr[15:8];
        REG_DPORT: begin
          n.rdata = st.rdat;
          if (st.io_mode) begin
            n.raddr = st.raddr + 16'h0001;
            n.rpf = 1'b1;
          end
        end
        REG_COLL:     n.rdata = {3'b000, st.coll};
        default: begin
          if (reg_addr[4:3] == REG_MAR_HI) begin
            n.rdata = st.mar[{reg_addr[2:0], 3'b000} +: 8];
          end else if (reg_addr[4:3] == REG_STA_HI && reg_addr[2:0] < STA_BYTES) begin
            n.rdata = st.sta[{reg_addr[2:0], 3'b000} +: 8];
          end
        end
      endcase
    end
    case (st.rs)
      R_IDLE: begin
        if (crs && st.rx_on) begin
          n.rs = R_PRE;
          n.prev1 = 1'b0;
        end
      end
      R_PRE: begin
        if (!crs) begin
          n.rs = R_IDLE;
        end else if (rxe) begin
          n.prev1 = rxd;
          if (rxd && st.prev1) begin
            n.rs = R_DATA;
            n.rcrc = CRC_INIT;
            n.rbit = 3'd0;
            n.rcnt = 16'h0000;
            n.rdma = {st.write_page, STAT_OFS};
          end
        end
      end
      R_DATA: begin
        if (!crs) begin
          if (st.rbit != 3'd0 || st.rcrc != CRC_RESIDUE || st.rcnt < RUNT_BYTES) begin
            set[ST_CRC_ERR] = (st.rcrc != CRC_RESIDUE);
            set[ST_RX_BAD] = 1'b1;
            n.rs = R_IDLE;
          end else begin
            n.rs = R_STAT;
            n.sidx = 2'd0;
            n.npg = (st.rdma[7:0] == 8'h00) ? st.rdma[15:8]
                  : next_page(st.rdma[15:8], st.ring_first_page, st.ring_end_page);
          end
        end else if (rxe) begin
          rb = {rxd, st.rsh[7:1]};
          n.rsh = rb;
          n.rcrc = crc_step(st.rcrc, rxd);
          n.rbit = st.rbit + 3'd1;
          if (st.rbit == 3'd7) begin
            n.rcnt = st.rcnt + 16'h0001;
            n.rwp = 1'b1;
            n.rwa = st.rdma;
            n.rwb = rb;
            n.rdma = st.rdma + 16'h0001;
            daf = {rb, st.da[47:8]};
            if (st.rcnt <= DA_LAST) begin
              n.da = daf;
            end
            if (st.rcnt == DA_LAST) begin
              // hash on crc after last address bit
              hash = n.rcrc[31:26];
              acc = st.rcfg[RCFG_PROM]
                  | (st.rcfg[RCFG_PHYS] & ~daf[0] & (daf == st.sta))
                  | (st.rcfg[RCFG_BCAST] & (&daf))
                  | (st.rcfg[RCFG_MCAST] & daf[0] & ~(&daf) & st.mar[hash]);
              n.mc = daf[0];
              if (!acc) begin
                n.rs = R_DROP;
              end
            end
            if (st.rdma[7:0] == 8'hFF) begin
              pg = next_page(st.rdma[15:8], st.ring_first_page, st.ring_end_page);
              if (pg == st.boundary_page) begin
                set[ST_RING_OVERWRITE_FLAG] = 1'b1;
                n.rs = R_DROP;
              end else begin
                n.rdma = {pg, 8'h00};
              end
            end
          end
        end
      end
      R_DROP: begin
        if (!crs) begin
          n.rs = R_IDLE;
        end
      end
      R_STAT: begin
        // status written at packet start page
        if (!st.rwp) begin
          n.rwp = 1'b1;
          n.rwa = {st.write_page, 6'h00, st.sidx};
          case (st.sidx)
            2'd0:    n.rwb = 8'((1 << RXS_OK) | (st.mc << RXS_MC));
            2'd1:    n.rwb = st.npg;
            2'd2:    n.rwb = st.rcnt[7:0];
            default: n.rwb = st.rcnt[15:8];
          endcase
          n.sidx = st.sidx + 2'd1;
          if (st.sidx == STAT_LAST) begin
            n.write_page = st.npg;
            set[ST_RX_OK] = 1'b1;
            n.rs = R_IDLE;
          end
        end
      end
      default: n.rs = R_IDLE;
    endcase
    case (st.ts)
      T_IDLE: begin
        if (st.tx_go && !st.tfp) begin
          n.taddr = {st.tpage, 8'h00};
          n.fleft = st.tcount;
          n.tleft = st.tcount;
          n.tnv = 1'b0;
          n.tcrc = CRC_INIT;
          n.tcnt = 7'd0;
          n.ts = T_PRE;
        end
      end
      T_PRE: begin
        if (txe) begin
          n.txen = 1'b1;
          n.txd = ~st.tcnt[0];
          n.tcnt = st.tcnt + 7'd1;
          if (st.tcnt == PRE_LAST) begin
            n.ts = T_SFD;
            n.tcnt = 7'd0;
          end
        end
      end
      T_SFD: begin
        if (txe) begin
          n.txd = 1'b1;
          n.tcnt = st.tcnt + 7'd1;
          if (st.tcnt == SFD_LAST) begin
            n.ts = T_DATA;
            n.tsh = st.tnext;
            n.tnv = 1'b0;
            n.tleft = st.tleft - 16'h0001;
            n.tbit = 3'd0;
          end
        end
      end
      T_DATA: begin
        if (txe) begin
          n.txd = st.tsh[0];
          n.tcrc = crc_step(st.tcrc, st.tsh[0]);
          n.tsh = {1'b0, st.tsh[7:1]};
          n.tbit = st.tbit + 3'd1;
          if (st.tbit == 3'd7) begin
            if (st.tleft == 16'h0000) begin
              n.ts = T_FCS;
              n.tcnt = 7'd0;
            end else begin
              n.tsh = st.tnext;
              n.tnv = 1'b0;
              n.tleft = st.tleft - 16'h0001;
            end
          end
        end
      end
      T_FCS: begin
        if (txe) begin
          n.txd = ~st.tcrc[31];
          n.tcrc = {st.tcrc[30:0], 1'b0};
          n.tcnt = st.tcnt + 7'd1;
          if (st.tcnt == FCS_LAST) begin
            n.ts = T_END;
          end
        end
      end
      T_END: begin
        if (txe) begin
          n.txen = 1'b0;
          n.txd = 1'b0;
          n.tx_go = 1'b0;
          n.coll = 5'd0;
          set[ST_TX_DONE] = 1'b1;
          n.ts = T_IDLE;
        end
      end
      T_JAM: begin
        if (txe) begin
          n.txd = 1'b1;
          n.tcnt = st.tcnt + 7'd1;
          if (st.tcnt == JAM_LAST) begin
            n.txen = 1'b0;
            n.txd = 1'b0;
            if (st.coll == MAX_RETRY) begin
              n.ts = T_IDLE;
              n.tx_go = 1'b0;
              n.coll = 5'd0;
              set[ST_TX_ABORT] = 1'b1;
            end else begin
              n.coll = st.coll + 5'd1;
              ce = (st.coll >= BO_EXP_MAX) ? BO_EXP_MAX : 5'(st.coll + 5'd1);
              mask = 10'((11'd1 << ce) - 11'd1);
              n.bo = 19'(st.lfsr & mask) << SLOT_SHIFT;
              n.ts = T_BACK;
            end
          end
        end
      end
      T_BACK: begin
        if (txe) begin
          if (st.bo == 19'h00000) begin
            n.ts = T_IDLE;
          end else begin
            n.bo = st.bo - 19'h00001;
          end
        end
      end
      default: n.ts = T_IDLE;
    endcase
    if (txe && colv && st.txen && st.ts inside {T_PRE, T_SFD, T_DATA, T_FCS}) begin
      n.ts = T_JAM;
      n.tcnt = 7'd0;
      n.txd = 1'b1;
    end
    n.stat = (st.stat & ~clr) | set;
    next_st = n;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign tx_data   = st.txd;
  assign tx_en     = st.txen;
  assign mem_addr  = st.maddr;
  assign mem_wdata = st.mwd;
  assign mem_we    = st.mwe;
  assign mem_re    = st.mre;

  logic [6:0] pcnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pcnt <= 7'd0;
    end else if (st.ts != T_PRE) begin
      pcnt <= 7'd0;
    end else if (txe) begin
      pcnt <= pcnt + 7'd1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_pre_len: assert property (st.ts == T_SFD && $past(st.ts) == T_PRE
    |-> pcnt == PRE_LAST + 7'd1) else $error("preamble length wrong");
  a_sfd_ones: assert property (st.ts == T_SFD && $past(st.ts) == T_SFD && $past(txe) |-> st.txd) else $error("delimiter bit not one");
  a_fcs_inv: assert property (st.ts == T_FCS && txe |=> st.txd == !$past(st.tcrc[31])) else $error("fcs bit wrong");
  a_start_off: assert property ($rose(st.rs == R_DATA) |-> st.rdma == {st.write_page, STAT_OFS}) else $error("packet not at offset four");
  a_no_endpg: assert property (st.rs == R_DATA && $changed(st.rdma[15:8]) && $past(st.rs) == R_DATA |-> st.rdma[15:8] != st.ring_end_page && st.rdma[7:0] == 8'h00) else $error("end page entered");
  a_no_bound: assert property (st.rs == R_DATA && $changed(st.rdma[15:8]) && $past(st.rs) == R_DATA |-> st.rdma[15:8] != st.boundary_page) else $error("boundary crossed");
  a_ovw_flag: assert property ($rose(st.stat[ST_RING_OVERWRITE_FLAG]) |-> $past(st.rs) == R_DATA && st.rs == R_DROP) else $error("overwrite flag without abort");
  a_stat_page: assert property (st.rs == R_STAT && st.rwp |-> st.rwa[15:8] == st.write_page) else $error("status outside start page");
  a_drop_quiet: assert property (st.rs == R_DROP && $past(st.rs) == R_DROP |-> !st.rwp) else $error("write after reject");
  a_coll_cap: assert property (st.coll <= MAX_RETRY) else $error("retry count exceeded");
  a_mem_excl: assert property (!(st.mwe && st.mre)) else $error("both strobes set");
  c_rx_ok: cover property ($rose(st.stat[ST_RX_OK]));
  c_tx_done: cover property ($rose(st.stat[ST_TX_DONE]));
  c_tx_abort: cover property ($rose(st.stat[ST_TX_ABORT]));
  c_overflow: cover property ($rose(st.stat[ST_RING_OVERWRITE_FLAG]));
endmodule : mac_core
`default_nettype wire

// file: tb/line_codec_model.sv
`default_nettype none
module line_codec_model (
  output logic      rx_clk,
  output logic      rx_data,
  output logic      rx_crs,
  output logic      tx_clk,
  output logic      col,
  input  wire logic tx_data,
  input  wire logic tx_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tx_run;
  logic tx_bits[$];
  initial begin
    {rx_clk, rx_data, rx_crs, tx_clk, col, tx_run} = 6'h00;
  end
  // transmit clock runs once tx_run is set, and tx_run is never cleared
  always #24 tx_clk = tx_run & ~tx_clk;
  always @(posedge tx_clk) begin
    if (tx_en) begin
      tx_bits.push_back(tx_data);
    end
  end
  task automatic bit_out(input logic b);
    rx_data = b;
    #24 rx_clk = 1'b1;
    #24 rx_clk = 1'b0;
  endtask : bit_out
  // collision raised for two bit times once n bits are out
  task automatic collide(input int n);
    wait (tx_en);
    repeat (n) @(posedge tx_clk);
    col = 1'b1;
    repeat (2) @(posedge tx_clk);
    col = 1'b0;
  endtask : collide
  // preamble of any even length, two ones, bytes lsb first
  task automatic send(input logic [7:0] f[$], input int np);
    #1 rx_crs = 1'b1;
    for (int i = 0; i < np + 2; i++) bit_out(i >= np || !i[0]);
    foreach (f[i]) for (int j = 0; j < 8; j++) bit_out(f[i][j]);
    rx_crs = 1'b0;
    rx_data = ~rx_data;
  endtask : send
endmodule : line_codec_model
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb
  import mac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  mem_rdata = 8'h00;
  logic [7:0]  reg_rdata, mem_wdata, wp, nw, r;
  logic [15:0] mem_addr;
  logic        mem_we, mem_re, rx_clk, rx_data, rx_crs, tx_clk, col, tx_data, tx_en;
  logic [7:0]  mem [0:65535];
  logic [7:0]  fr[$];
  logic [7:0]  sta[6];
  logic [31:0] e;
  logic        eb[$];
  int          mismatches = 0;
  int          checked = 0;
  int          off = 0;
  int          cyc = 0;
  int          seed = 32'hc833;
  int          cf[7] = '{1, 1, 1, 2, 1, 4, 8};
  int          dk[7] = '{0, 0, 1, 2, 2, 3, 1};
  int          ok[7] = '{1, 0, 0, 1, 0, 1, 1};
  mac_core mac_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_clk(rx_clk), .rx_data(rx_data), .rx_crs(rx_crs), .tx_clk(tx_clk), .col(col),
    .tx_data(tx_data), .tx_en(tx_en), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
  line_codec_model line_codec_model_inst (.rx_clk(rx_clk), .rx_data(rx_data),
    .rx_crs(rx_crs), .tx_clk(tx_clk), .col(col), .tx_data(tx_data), .tx_en(tx_en));
  always #2 clk_sys = ~clk_sys;
  // buffer memory: read data only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // frame: destination, source, length, n data bytes, then crc lsb first
  task automatic mk(input int kind, input int n);
    logic [31:0] x;
    fr.delete();
    for (int i = 0; i < 6; i++)
      fr.push_back(kind == 2 ? 8'hFF : sta[i] ^ 8'(kind == 3 && i == 0 || kind == 1 && i == 5));
    for (int i = 0; i < 8 + n; i++) fr.push_back(8'($random(seed)));
    x = 32'hFFFFFFFF;
    foreach (fr[i]) for (int j = 0; j < 8; j++)
      x = (x >> 1) ^ ((x[0] ^ fr[i][j]) ? 32'hEDB88320 : 32'h00000000);
    for (int j = 0; j < 4; j++) fr.push_back(~x[8*j +: 8]);
  endtask : mk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(5'h0E, 8'hA5);
    for (int a = 0; a < 32; a++) begin
      rd(5'(a), r);
      chk(r, 8'h00);
    end
    $display("reset values done");
    // ring set up by software, first page nonzero
    wr(REG_FIRST, 8'h40);
    wr(REG_END, 8'h43);
    wr(REG_BOUNDARY, 8'h40);
    wr(REG_WPAGE, 8'h40);
    wp = 8'h40;
    for (int i = 0; i < 8; i++) begin
      sta[i % 6] = 8'($random(seed)) & 8'hFE;
      wr(5'(16 + i % 6), sta[i % 6]);
      wr(5'(24 + i), 8'hFF);
    end
    wr(REG_CMD, 8'h01);
    // each acceptance mode against a destination it accepts, physical mode also against foreign and broadcast ones
    for (int k = 0; k < 7; k++) begin
      wr(REG_RCFG, 8'(cf[k]));
      wr(REG_STAT, 8'hFF);
      mk(dk[k], 46);
      if (k == 1) fr[20] = ~fr[20];
      line_codec_model_inst.send(fr, 62 - 2 * k);
      repeat (20) @(posedge clk_sys);
      rd(REG_STAT, r);
      chk(r[1:0], k == 1 ? 2'b10 : 2'(ok[k]));
      if (ok[k]) begin
        nw = (wp + 8'h01 == 8'h43) ? 8'h40 : wp + 8'h01;
        foreach (fr[i]) chk(mem[{wp, 8'(i + 4)}], fr[i]);
        e = {mem[{wp, 8'h00}], mem[{wp, 8'h01}], mem[{wp, 8'h02}], mem[{wp, 8'h03}]};
        chk(e, {2'b00, dk[k] >= 2, 4'h0, 1'b1, nw, 8'h40, 8'h00});
        wp = nw;
        wr(REG_BOUNDARY, wp);
      end
      rd(REG_WPAGE, r);
      chk(r, wp);
    end
    $display("receive filter done");
    // linking into the boundary page aborts
    wr(REG_BOUNDARY, wp + 8'h01);
    wr(REG_RCFG, 8'h01);
    wr(REG_STAT, 8'hFF);
    mk(0, 240);
    line_codec_model_inst.send(fr, 62);
    repeat (20) @(posedge clk_sys);
    rd(REG_STAT, r);
    chk(r[2:0], 3'b100);
    rd(REG_WPAGE, r);
    chk(r, wp);
    $display("ring overflow done");
    mk(1, 46);
    for (int i = 0; i < fr.size() - 4; i++) mem[{8'h20, 8'(i)}] = fr[i];
    wr(REG_TPAGE, 8'h20);
    wr(REG_TCNT_LO, 8'(fr.size() - 4));
    wr(REG_TCNT_HI, 8'h00);
    for (int i = 0; i < 64; i++) eb.push_back(i > 61 || !i[0]);
    foreach (fr[i]) for (int j = 0; j < 8; j++) eb.push_back(fr[i][j]);
    line_codec_model_inst.tx_run = 1'b1;
    wr(REG_CMD, 8'h03);
    wait (tx_en);
    wait (!tx_en);
    repeat (20) @(posedge clk_sys);
    chk(line_codec_model_inst.tx_bits.size(), eb.size());
    foreach (eb[i]) chk(line_codec_model_inst.tx_bits[i], eb[i]);
    rd(REG_STAT, r);
    chk(r[3], 1'b1);
    $display("transmit done");
    // boundary seeds the remote read in io mode
    wr(REG_BOUNDARY, 8'h41);
    wr(REG_CMD, 8'h0D);
    for (int i = 0; i < 2; i++) begin
      repeat (4) @(posedge clk_sys);
      rd(REG_DPORT, r);
      chk(r, mem[{8'h41, 8'(i)}]);
    end
    $display("remote read done");
    // collision in the preamble: jam, count, back off, resend
    wr(REG_STAT, 8'hFF);
    mk(1, 0);
    for (int i = 0; i < 14; i++) mem[{8'h20, 8'(i)}] = fr[i];
    wr(REG_TCNT_LO, 8'h0E);
    eb.delete();
    for (int i = 0; i < 96; i++) eb.push_back(i < 32 || i > 93 || !i[0]);
    foreach (fr[i]) for (int j = 0; j < 8; j++) eb.push_back(fr[i][j]);
    line_codec_model_inst.tx_bits.delete();
    wr(REG_CMD, 8'h03);
    line_codec_model_inst.collide(8);
    wait (!tx_en);
    rd(REG_COLL, r);
    chk(r, 8'h01);
    wait (tx_en);
    wait (!tx_en);
    repeat (20) @(posedge clk_sys);
    off = line_codec_model_inst.tx_bits.size() - eb.size();
    chk(off > 0, 1'b1);
    foreach (eb[i]) chk(line_codec_model_inst.tx_bits[off + i], eb[i]);
    rd(REG_STAT, r);
    chk(r[4:3], 2'b01);
    $display("collision retry done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
